// ===== verilog/utw_pkg.sv
// utw_pkg: offsets, field layout and reset values of the upstream
// traffic-class window registers; shared by the register bank and its bench.
package utw_pkg;
   // register offsets inside the device control memory window
   localparam logic [7:0] UTW_OFF_LIMIT0 = 8'h10;
   localparam logic [7:0] UTW_OFF_CTRL1  = 8'h14;
   localparam logic [7:0] UTW_OFF_BASE1  = 8'h18;
   localparam logic [7:0] UTW_OFF_LIMIT1 = 8'h1C;
   localparam logic [7:0] UTW_OFF_CTRL2  = 8'h20;
   localparam logic [7:0] UTW_OFF_BASE2  = 8'h24;
   localparam logic [7:0] UTW_OFF_LIMIT2 = 8'h28;

   // control register layout
   localparam int UTW_CTRL_W     = 4;   // implemented low bits of the control word
   localparam int UTW_EN_BIT     = 0;
   localparam int UTW_TC_LSB     = 1;
   localparam int UTW_TC_MSB     = 3;
   localparam int UTW_TC_W       = 3;

   // reset values
   localparam logic [3:0]  UTW_CTRL_RST  = 4'h0;
   localparam logic [31:0] UTW_ADDR_RST  = 32'h0000_0000;
   localparam logic [2:0]  UTW_TC_ZERO   = 3'h0;

   // number of windows the bridge supports, reported read-only
   localparam logic [3:0]  UTW_WIN_COUNT = 4'h4;
endpackage

// ===== verilog/utw_regs.sv
// utw_regs: upstream traffic-class window registers (window 0 limit,
// windows 1 and 2 complete) and the address-to-class lookup they steer.
// Assumes the register port and the request port come from logic on clock_i;
// window 0 control and base live in a neighbouring bank and arrive as inputs.
//
// Functional notes
// RULE_01: limit registers 32-bit read/write, reset zero
// RULE_02: base/limit stay read/write while window disabled
// RULE_03: base registers 32-bit read/write, reset zero
// RULE_04: control bits 15..4 read zero, ignore writes
// RULE_05: control registers reset to zero
// RULE_06: control bits 3..1 select traffic class
// RULE_07: control bit 0 enables window; off means ignored
// RULE_08: enabled window hit gets its traffic class
// RULE_09: window 1 at 14h/18h/1Ch; limit 0 at 10h
// RULE_10: window 2 at 20h, 24h, 28h
// RULE_11: global enable off forces class zero
// RULE_12: report four windows in read-only count field
// RULE_13: inclusive bounds; lowest window wins overlaps
`timescale 1ns/1ns
module utw_regs #(
   parameter int NUM_WIN = 3
) (
   input  wire logic                         clock_i,
   input  wire logic                         rst_n_i,
   // register port
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   input  wire logic [7:0]                   reg_addr_i,
   input  wire logic [31:0]                  reg_wdata_i,
   output logic      [31:0]                  reg_rdata_o,
   output logic                              reg_rvalid_o,
   // state held elsewhere in the bridge
   input  wire logic                         global_class_map_enable_i,
   input  wire logic [utw_pkg::UTW_CTRL_W-1:0] win0_ctrl_i,
   input  wire logic [31:0]                  win0_base_i,
   output logic      [3:0]                   window_count_field_o,
   // upstream request lookup
   input  wire logic                         up_req_i,
   input  wire logic [31:0]                  up_addr_i,
   output logic                              up_valid_o,
   output logic                              up_hit_o,
   output logic      [utw_pkg::UTW_TC_W-1:0] up_tc_o
);
   import utw_pkg::*;

   // address match helper, used by both the write and the read decode
   function automatic logic at(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // storage: index 0 of ctrl/base is unused here (window 0 comes in on ports)
   logic [UTW_CTRL_W-1:0] ctrl_r  [NUM_WIN];
   logic [31:0]           base_r  [NUM_WIN];
   logic [31:0]           limit_r [NUM_WIN];

   logic [31:0]           rdata_r;
   logic [31:0]           rdata_nxt;
   logic                  rvalid_r;
   logic                  up_valid_r;
   logic                  up_hit_r;
   logic                  up_hit_nxt;
   logic [UTW_TC_W-1:0]   up_tc_r;
   logic [UTW_TC_W-1:0]   up_tc_nxt;

   // write decode per register
   wire wr_limit0 = reg_wr_i && at(reg_addr_i, UTW_OFF_LIMIT0);
   wire wr_ctrl1  = reg_wr_i && at(reg_addr_i, UTW_OFF_CTRL1);
   wire wr_base1  = reg_wr_i && at(reg_addr_i, UTW_OFF_BASE1);
   wire wr_limit1 = reg_wr_i && at(reg_addr_i, UTW_OFF_LIMIT1);
   wire wr_ctrl2  = reg_wr_i && at(reg_addr_i, UTW_OFF_CTRL2);
   wire wr_base2  = reg_wr_i && at(reg_addr_i, UTW_OFF_BASE2);
   wire wr_limit2 = reg_wr_i && at(reg_addr_i, UTW_OFF_LIMIT2);

   // writes are accepted whatever the enable bit says: disabled windows are
   // plain scratch storage [RULE_02]
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_WIN; i++) begin
            ctrl_r[i]  <= UTW_CTRL_RST;   // [RULE_05]
            base_r[i]  <= UTW_ADDR_RST;   // [RULE_03]
            limit_r[i] <= UTW_ADDR_RST;   // [RULE_01]
         end
      end else begin
         if (wr_limit0) limit_r[0] <= reg_wdata_i;            // [RULE_01] [RULE_09]
         if (wr_ctrl1)  ctrl_r[1]  <= reg_wdata_i[3:0];       // [RULE_04] [RULE_09]
         if (wr_base1)  base_r[1]  <= reg_wdata_i;            // [RULE_03] [RULE_09]
         if (wr_limit1) limit_r[1] <= reg_wdata_i;            // [RULE_01] [RULE_09]
         if (wr_ctrl2)  ctrl_r[2]  <= reg_wdata_i[3:0];       // [RULE_04] [RULE_10]
         if (wr_base2)  base_r[2]  <= reg_wdata_i;            // [RULE_03] [RULE_10]
         if (wr_limit2) limit_r[2] <= reg_wdata_i;            // [RULE_01] [RULE_10]
      end
   end

   // read mux; control words zero-extend so bits 31..4 read zero, and an
   // unmapped offset reads zero [RULE_04]
   assign rdata_nxt =
      at(reg_addr_i, UTW_OFF_LIMIT0) ? limit_r[0] :
      at(reg_addr_i, UTW_OFF_CTRL1)  ? {28'h0000000, ctrl_r[1]} :
      at(reg_addr_i, UTW_OFF_BASE1)  ? base_r[1] :
      at(reg_addr_i, UTW_OFF_LIMIT1) ? limit_r[1] :
      at(reg_addr_i, UTW_OFF_CTRL2)  ? {28'h0000000, ctrl_r[2]} :
      at(reg_addr_i, UTW_OFF_BASE2)  ? base_r[2] :
      at(reg_addr_i, UTW_OFF_LIMIT2) ? limit_r[2] : 32'h0000_0000;

   // read data is registered: one cycle from strobe to rvalid
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= reg_rd_i ? rdata_nxt : rdata_r;
         rvalid_r <= reg_rd_i;
      end
   end

   assign reg_rdata_o          = rdata_r;
   assign reg_rvalid_o         = rvalid_r;
   assign window_count_field_o = UTW_WIN_COUNT;   // [RULE_12]

   // per-window view: window 0 control and base come from outside
   logic                win_en  [NUM_WIN];
   logic [UTW_TC_W-1:0] win_tc  [NUM_WIN];
   logic [31:0]         win_lo  [NUM_WIN];
   logic [NUM_WIN-1:0]  win_hit;

   genvar g;
   generate
      for (g = 0; g < NUM_WIN; g++) begin : g_win
         if (g == 0) begin : g_ext
            assign win_en[g] = win0_ctrl_i[UTW_EN_BIT];
            assign win_tc[g] = win0_ctrl_i[UTW_TC_MSB:UTW_TC_LSB];
            assign win_lo[g] = win0_base_i;
         end else begin : g_loc
            assign win_en[g] = ctrl_r[g][UTW_EN_BIT];                // [RULE_07]
            assign win_tc[g] = ctrl_r[g][UTW_TC_MSB:UTW_TC_LSB];     // [RULE_06]
            assign win_lo[g] = base_r[g];
         end
         // inclusive bounds; global enable gates every window [RULE_13] [RULE_11]
         assign win_hit[g] = global_class_map_enable_i && win_en[g]
                             && (up_addr_i >= win_lo[g]) && (up_addr_i <= limit_r[g]);
      end
   endgenerate

   // priority pick: scan from the top so the lowest hit ends up chosen
   always_comb begin
      up_hit_nxt = 1'b0;
      up_tc_nxt  = UTW_TC_ZERO;                    // [RULE_11]
      for (int i = NUM_WIN - 1; i >= 0; i--) begin
         if (win_hit[i]) begin
            up_hit_nxt = 1'b1;
            up_tc_nxt  = win_tc[i];                // [RULE_08] [RULE_13]
         end
      end
   end

   // lookup result registered: answer one cycle after the request
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_valid_r <= 1'b0;
         up_hit_r   <= 1'b0;
         up_tc_r    <= UTW_TC_ZERO;
      end else begin
         up_valid_r <= up_req_i;
         up_hit_r   <= up_req_i ? up_hit_nxt : up_hit_r;
         up_tc_r    <= up_req_i ? up_tc_nxt  : up_tc_r;
      end
   end

   assign up_valid_o = up_valid_r;
   assign up_hit_o   = up_hit_r;
   assign up_tc_o    = up_tc_r;

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   limit_store_a: assert property ( // [RULE_01]
      wr_limit1 |=> limit_r[1] == $past(reg_wdata_i))
      else $error("window 1 limit did not take the written value");

   base_store_a: assert property ( // [RULE_03]
      wr_base2 |=> base_r[2] == $past(reg_wdata_i))
      else $error("window 2 base did not take the written value");

   scratch_rw_a: assert property ( // [RULE_02]
      wr_base1 && !ctrl_r[1][UTW_EN_BIT] ##1 reg_rd_i && at(reg_addr_i, UTW_OFF_BASE1)
      && !reg_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("disabled window base not readable back");

   ctrl_reserved_bits_a: assert property ( // [RULE_04]
      reg_rd_i && (at(reg_addr_i, UTW_OFF_CTRL1) || at(reg_addr_i, UTW_OFF_CTRL2))
      |=> reg_rvalid_o && reg_rdata_o[31:4] == 28'h0000000)
      else $error("control upper bits not zero");

   tc_field_a: assert property ( // [RULE_06]
      wr_ctrl2 |=> win_tc[2] == $past(reg_wdata_i[3:1]))
      else $error("traffic class field not written");

   no_window_a: assert property ( // [RULE_07]
      up_req_i && !win_en[0] && !win_en[1] && !win_en[2]
      |=> up_valid_o && !up_hit_o && up_tc_o == 3'h0)
      else $error("disabled windows changed the class");

   hit_map_a: assert property ( // [RULE_08]
      up_req_i && win_hit[1] && !win_hit[0] |=> up_hit_o && up_tc_o == $past(win_tc[1]))
      else $error("hit on window 1 did not take its class");

   global_off_a: assert property ( // [RULE_11]
      up_req_i && !global_class_map_enable_i |=> !up_hit_o && up_tc_o == 3'h0)
      else $error("class mapped with global enable off");

   limit0_read_a: assert property ( // [RULE_09]
      reg_rd_i && at(reg_addr_i, UTW_OFF_LIMIT0) |=> reg_rdata_o == $past(limit_r[0]))
      else $error("window 0 limit read wrong");

   prio_low_a: assert property ( // [RULE_13]
      up_req_i && win_hit[0] |=> up_tc_o == $past(win_tc[0]))
      else $error("lowest window lost priority");
endmodule // utw_regs

// ===== tb/tb.sv
// tb: self-checking bench for the upstream traffic-class window registers.
// Assumes utw_pkg and utw_regs are compiled first; the bench drives every port.
`timescale 1ns/1ns
module tb;
   import utw_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic [31:0] reg_rdata_o;
   logic        reg_rvalid_o;
   logic        gen_i = 1'b0;
   logic [3:0]  win0_ctrl_i = 4'h0;
   logic [31:0] win0_base_i = 32'h0000_0000;
   logic [3:0]  count_o;
   logic        up_req_i = 1'b0;
   logic [31:0] up_addr_i = 32'h0000_0000;
   logic        up_valid_o, up_hit_o;
   logic [2:0]  up_tc_o;
   int          fails = 0;
   int          total_checks = 0;
   logic [7:0]  offs [7] = '{UTW_OFF_LIMIT0, UTW_OFF_CTRL1, UTW_OFF_BASE1, UTW_OFF_LIMIT1,
                              UTW_OFF_CTRL2, UTW_OFF_BASE2, UTW_OFF_LIMIT2};

   utw_regs dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .global_class_map_enable_i(gen_i), .win0_ctrl_i(win0_ctrl_i),
      .win0_base_i(win0_base_i), .window_count_field_o(count_o), .up_req_i(up_req_i),
      .up_addr_i(up_addr_i), .up_valid_o(up_valid_o), .up_hit_o(up_hit_o),
      .up_tc_o(up_tc_o));

   // free-running 100 MHz clock
   always #5 clock_i = ~clock_i;

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_look(input logic [4:0] got, input logic [4:0] exp);
      chk_reg({27'h0, got}, {27'h0, exp});
   endtask

   // strobes go up just after an edge and drop just after the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i); #1;
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge clock_i); #1;
      reg_wr_i = 1'b0;
   endtask

   // read answer is registered, so it is judged one edge after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_i); #1;
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(posedge clock_i); #1;
      reg_rd_i = 1'b0;
      chk_reg(reg_rvalid_o ? reg_rdata_o : ~e, e);
   endtask

   // expected is {valid, hit, class}
   task automatic look(input logic [31:0] a, input logic [4:0] e);
      @(posedge clock_i); #1;
      up_req_i = 1'b1;
      up_addr_i = a;
      @(posedge clock_i); #1;
      up_req_i = 1'b0;
      chk_look({up_valid_o, up_hit_o, up_tc_o}, e);
   endtask

   task automatic t_reset;
      for (int i = 0; i < 7; i++) rd(offs[i], 32'h0000_0000);
      rd(8'h30, 32'h0000_0000);
      chk_reg({28'h0, count_o}, 32'h0000_0004);
   endtask

   // low nibble E keeps both windows disabled while every bit is exercised
   task automatic t_rw;
      gen_i = 1'b1;
      for (int i = 0; i < 7; i++) wr(offs[i], 32'hA53C_96EE + i * 32'h100);
      for (int i = 0; i < 7; i++)
         rd(offs[i], (i == 1 || i == 4) ? 32'h0000_000E : 32'hA53C_96EE + i * 32'h100);
      look(32'hA53C_98EE, 5'h10);
   endtask

   // back-to-back strobes with window 1 still disabled: a read right after a
   // write sees the new word, a read in the same cycle as a write the old one
   task automatic t_b2b;
      @(posedge clock_i); #1;
      reg_wr_i = 1'b1;
      reg_addr_i = UTW_OFF_BASE1;
      reg_wdata_i = 32'h5AC3_0F96;
      @(posedge clock_i); #1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b1;
      @(posedge clock_i); #1;
      chk_reg({31'h0, reg_rvalid_o}, 32'h0000_0001);
      chk_reg(reg_rdata_o, 32'h5AC3_0F96);
      reg_wr_i = 1'b1;
      reg_addr_i = UTW_OFF_LIMIT1;
      reg_wdata_i = 32'h3C96_A50F;
      @(posedge clock_i); #1;
      chk_reg(reg_rdata_o, 32'hA53C_99EE);
      reg_wr_i = 1'b0;
      @(posedge clock_i); #1;
      reg_rd_i = 1'b0;
      chk_reg(reg_rdata_o, 32'h3C96_A50F);
      @(posedge clock_i); #1;
      chk_reg({31'h0, reg_rvalid_o}, 32'h0000_0000);
      chk_reg(reg_rdata_o, 32'h3C96_A50F);
   endtask

   task automatic t_map;
      logic [31:0] ad [8] = '{32'h07FF, 32'h0800, 32'h1000, 32'h1800,
                              32'h1FFF, 32'h2000, 32'h2FFF, 32'h3000};
      logic [4:0]  ex [8] = '{5'h10, 5'h1E, 5'h1D, 5'h1D, 5'h1D, 5'h1B, 5'h1B, 5'h10};
      win0_base_i = 32'h0000_0800;
      win0_ctrl_i = 4'hD;
      wr(UTW_OFF_LIMIT0, 32'h0000_0FFF);
      wr(UTW_OFF_BASE1, 32'h0000_1000);
      wr(UTW_OFF_LIMIT1, 32'h0000_1FFF);
      wr(UTW_OFF_CTRL1, 32'hFFFF_FFFB);
      wr(UTW_OFF_BASE2, 32'h0000_1800);
      wr(UTW_OFF_LIMIT2, 32'h0000_2FFF);
      wr(UTW_OFF_CTRL2, 32'h0000_0007);
      for (int i = 0; i < 8; i++) look(ad[i], ex[i]);
      wr(UTW_OFF_LIMIT0, 32'h0000_1FFF);
      look(32'h0000_1800, 5'h1E);
      gen_i = 1'b0;
      look(32'h0000_1800, 5'h10);
   endtask

   // reset in mid-run clears every register and the held lookup answer;
   // window 0 control stays enabled outside, but its limit is back to zero
   task automatic t_rst2;
      gen_i = 1'b1;
      look(32'h0000_1800, 5'h1E);
      @(posedge clock_i); #1;
      chk_look({up_valid_o, up_hit_o, up_tc_o}, 5'h0E);
      rst_n_i = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      chk_look({up_valid_o, up_hit_o, up_tc_o}, 5'h00);
      rst_n_i = 1'b1;
      look(32'h0000_1800, 5'h10);
      for (int i = 0; i < 7; i++) rd(offs[i], 32'h0000_0000);
   endtask

   // hang guard, far beyond the roughly 125 cycles the tests need
   initial begin
      #200000;
      fails++;
      test_done;
   end

   initial begin
      repeat (16) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      t_reset;
      t_rw;
      t_b2b;
      t_map;
      t_rst2;
      test_done;
   end
endmodule // tb
